//--- rtl/pwm_channel_pkg.sv
// shared constants for the standard pwm channel
package pwm_channel_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned NUM_TIMERS = 3;
  // register byte addresses
  localparam logic [7:0] OFS_CHANNEL_CONTROL = 8'h00;
  localparam logic [7:0] OFS_DUTY_SETTING_MSBS = 8'h04;
  localparam logic [7:0] OFS_ACTIVE_DUTY_BUFFER = 8'h08;
  localparam logic [7:0] OFS_TIMER_SELECT = 8'h0C;
  localparam logic [7:0] OFS_PIN_DIRECTION = 8'h10;
  localparam logic [7:0] OFS_TIMER_CTRL_A = 8'h14;
  localparam logic [7:0] OFS_PERIOD_LIMIT_A = 8'h20;
  localparam logic [7:0] OFS_PERIOD_COUNT_A = 8'h2C;
  localparam logic [7:0] OFS_TIMER_STRIDE = 8'h04;
  // field positions
  localparam int unsigned DUTY_LSB_POS = 4;
  localparam int unsigned MODE_POS = 0;
  localparam int unsigned RUN_POS = 2;
  localparam int unsigned PRESCALE_POS = 0;
  localparam int unsigned POSTSCALE_POS = 3;
  // channel_mode_select values whose upper two bits are ones select pwm
  localparam logic [1:0] MODE_PWM_HI = 2'h3;
  // reset values
  localparam logic [7:0] RST_CHANNEL_CONTROL = 8'h00;
  localparam logic [7:0] RST_DUTY = 8'h00;
  localparam logic [1:0] RST_TIMER_SELECT = 2'h0;
  localparam logic RST_PIN_DIRECTION = 1'b1;
  localparam logic [7:0] RST_TIMER_CTRL = 8'h00;
  localparam logic [7:0] RST_PERIOD_LIMIT = 8'hFF;
  localparam logic [7:0] RST_PERIOD_COUNT = 8'h00;
  // prescale counter terminal counts: 4 clocks times ratio 1, 4 or 16
  localparam logic [5:0] PRESC_LIM_1 = 6'h03;
  localparam logic [5:0] PRESC_LIM_4 = 6'h0F;
  localparam logic [5:0] PRESC_LIM_16 = 6'h3F;
  localparam logic [1:0] CKPS_1 = 2'h0;
  localparam logic [1:0] CKPS_4 = 2'h1;
endpackage

//--- rtl/pwm_channel.sv
// standard pwm channel with three period timers and avalon-mm registers
//
// Operation
// R01 - period comes from one of three 8-bit timers picked by timer_source_field
// R02 - period is (period_limit+1) times 4 clocks times prescale ratio
// R03 - counter at period_limit clears to zero on next increment
// R04 - pin goes high at each period start unless duty is zero
// R05 - at rollover the written duty is copied into active_duty_buffer
// R06 - postscale_select has no effect on pwm timing
// R07 - duty is duty_setting_msbs above duty_setting_lsbs, 10 bits
// R08 - duty writes are free any time, take effect only after rollover
// R09 - active_duty_buffer ignores software writes while pwm mode runs
// R10 - high time is duty times one clock times prescale ratio
// R11 - 10-bit time base is counter plus two phase or prescaler bits
// R12 - time base equal to active duty drives pin low
// R13 - resolution follows period_limit, full ten bits only at 255
// R14 - duty beyond period never matches, pin keeps its level
// R15 - prescale ratios are 1, 4 and 16
// R16 - sleep freezes counter and channel state, pin holds its level
// R17 - reset restores all registers and makes the pin an input
// R18 - software clears pin_direction before the waveform can appear
// R19 - clearing channel_control releases the pin from pwm control
// R20 - running counter steps every 4 times prescale clocks
//
// The address map and register access over Avalon-MM are this design's own decisions.
module pwm_channel
  import pwm_channel_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic sleep_req,
  output logic pwm_output_pin,
  output logic pwm_output_pin_oe_n
);

  function automatic logic [5:0] presc_lim(input logic [1:0] ckps);
    case (ckps)
      CKPS_1: presc_lim = PRESC_LIM_1;
      CKPS_4: presc_lim = PRESC_LIM_4;
      default: presc_lim = PRESC_LIM_16;
    endcase
  endfunction

  function automatic logic [1:0] tb_low(input logic [5:0] presc, input logic [1:0] ckps);
    case (ckps)
      CKPS_1: tb_low = presc[1:0];
      CKPS_4: tb_low = presc[3:2];
      default: tb_low = presc[5:4];
    endcase
  endfunction

  function automatic logic [7:0] tmr_ofs(input logic [7:0] base, input int unsigned idx);
    tmr_ofs = base + 8'(idx * OFS_TIMER_STRIDE);
  endfunction

  // bus slave state
  logic wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wr_en;

  // register state
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [7:0] duty_msbs_r, duty_msbs_nxt;
  logic [1:0] tsel_r, tsel_nxt;
  logic dir_r, dir_nxt;

  // timers
  logic [7:0] tcon_r [NUM_TIMERS];
  logic [7:0] tcon_nxt [NUM_TIMERS];
  logic [7:0] pr_r [NUM_TIMERS];
  logic [7:0] pr_nxt [NUM_TIMERS];
  logic [7:0] tmr_r [NUM_TIMERS];
  logic [7:0] tmr_nxt [NUM_TIMERS];
  logic [5:0] presc_r [NUM_TIMERS];
  logic [5:0] presc_nxt [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] tick;

  // pwm core
  logic [7:0] active_r, active_nxt;
  logic [1:0] latch_r, latch_nxt;
  logic level_r, level_nxt;
  logic oe_n_r, oe_n_nxt;
  logic [1:0] s;
  logic roll, run_sel, pwm_mode;
  logic [9:0] tb, tb_nxt, duty_act, duty_new;
  logic [5:0] gap_r, gap_nxt;
  logic gap_ok_r, gap_ok_nxt;

  assign wr_en = write & ~wait_r & byteenable[0];
  assign pwm_mode = (ctrl_r[MODE_POS+3:MODE_POS+2] == MODE_PWM_HI);
  assign readdata = rdata_r;
  assign waitrequest = wait_r;
  assign pwm_output_pin = level_r;
  assign pwm_output_pin_oe_n = oe_n_r;

  // bus handshake, one wait state then answer
  always_comb begin
    wait_nxt = 1'b1;
    rdata_nxt = rdata_r;
    if ((read | write) & wait_r) begin
      wait_nxt = 1'b0;
    end
    if (read & wait_r) begin
      rdata_nxt = 32'h0000_0000;
      case (address)
        OFS_CHANNEL_CONTROL: rdata_nxt[7:0] = ctrl_r;
        OFS_DUTY_SETTING_MSBS: rdata_nxt[7:0] = duty_msbs_r;
        OFS_ACTIVE_DUTY_BUFFER: rdata_nxt[7:0] = active_r;
        OFS_TIMER_SELECT: rdata_nxt[1:0] = tsel_r;
        OFS_PIN_DIRECTION: rdata_nxt[0] = dir_r;
        default: begin
          for (int i = 0; i < NUM_TIMERS; i++) begin
            if (address == tmr_ofs(OFS_TIMER_CTRL_A, i)) rdata_nxt[7:0] = tcon_r[i];
            if (address == tmr_ofs(OFS_PERIOD_LIMIT_A, i)) rdata_nxt[7:0] = pr_r[i];
            if (address == tmr_ofs(OFS_PERIOD_COUNT_A, i)) rdata_nxt[7:0] = tmr_r[i];
          end
        end
      endcase
    end
    if (sys_rst) begin
      wait_nxt = 1'b1;
      rdata_nxt = 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk) begin
    wait_r <= wait_nxt;
    rdata_r <= rdata_nxt;
  end

  // software registers
  always_comb begin
    ctrl_nxt = ctrl_r;
    duty_msbs_nxt = duty_msbs_r;
    tsel_nxt = tsel_r;
    dir_nxt = dir_r;
    if (wr_en) begin
      case (address)
        OFS_CHANNEL_CONTROL: ctrl_nxt = writedata[7:0]; // R08 R19
        OFS_DUTY_SETTING_MSBS: duty_msbs_nxt = writedata[7:0]; // R08
        OFS_TIMER_SELECT: tsel_nxt = writedata[1:0]; // R01
        OFS_PIN_DIRECTION: dir_nxt = writedata[0];
        default: ;
      endcase
    end
    if (sys_rst) begin
      ctrl_nxt = RST_CHANNEL_CONTROL; // R17
      duty_msbs_nxt = RST_DUTY;
      tsel_nxt = RST_TIMER_SELECT;
      dir_nxt = RST_PIN_DIRECTION;
    end
  end

  always_ff @(posedge mclk) begin
    ctrl_r <= ctrl_nxt;
    duty_msbs_r <= duty_msbs_nxt;
    tsel_r <= tsel_nxt;
    dir_r <= dir_nxt;
  end

  // three period timers; postscale bits are stored only
  always_comb begin
    for (int i = 0; i < NUM_TIMERS; i++) begin
      tcon_nxt[i] = tcon_r[i];
      pr_nxt[i] = pr_r[i];
      tmr_nxt[i] = tmr_r[i];
      presc_nxt[i] = presc_r[i];
      tick[i] = tcon_r[i][RUN_POS] & ~sleep_req & (presc_r[i] == presc_lim(tcon_r[i][1:0])); // R20 R15 R06
      if (tcon_r[i][RUN_POS] & ~sleep_req) begin // R16
        presc_nxt[i] = tick[i] ? 6'h00 : presc_r[i] + 6'h01; // R02
      end
      if (tick[i]) begin
        tmr_nxt[i] = (tmr_r[i] == pr_r[i]) ? 8'h00 : tmr_r[i] + 8'h01; // R03
      end
      if (wr_en & (address == tmr_ofs(OFS_TIMER_CTRL_A, i))) tcon_nxt[i] = writedata[7:0];
      if (wr_en & (address == tmr_ofs(OFS_PERIOD_LIMIT_A, i))) pr_nxt[i] = writedata[7:0];
      if (wr_en & (address == tmr_ofs(OFS_PERIOD_COUNT_A, i))) begin
        tmr_nxt[i] = writedata[7:0];
        presc_nxt[i] = 6'h00;
      end
      if (sys_rst) begin
        tcon_nxt[i] = RST_TIMER_CTRL; // R17
        pr_nxt[i] = RST_PERIOD_LIMIT;
        tmr_nxt[i] = RST_PERIOD_COUNT;
        presc_nxt[i] = 6'h00;
      end
    end
  end

  always_ff @(posedge mclk) begin
    for (int i = 0; i < NUM_TIMERS; i++) begin
      tcon_r[i] <= tcon_nxt[i];
      pr_r[i] <= pr_nxt[i];
      tmr_r[i] <= tmr_nxt[i];
      presc_r[i] <= presc_nxt[i];
    end
  end

  // selected time base and compare
  always_comb begin
    s = (tsel_r > 2'h2) ? 2'h0 : tsel_r; // R01
    run_sel = tcon_r[s][RUN_POS] & ~sleep_req;
    roll = tick[s] & (tmr_r[s] == pr_r[s]); // R03
    tb = {tmr_r[s], tb_low(presc_r[s], tcon_r[s][1:0])}; // R11 R13
    tb_nxt = {tmr_nxt[s], tb_low(presc_nxt[s], tcon_r[s][1:0])}; // R10 R12
    duty_act = {active_r, latch_r};
    duty_new = {duty_msbs_r, ctrl_r[DUTY_LSB_POS+1:DUTY_LSB_POS]}; // R07
  end

  // pwm output and duty double buffer
  always_comb begin
    active_nxt = active_r;
    latch_nxt = latch_r;
    level_nxt = level_r;
    if (pwm_mode) begin
      if (roll) begin
        active_nxt = duty_msbs_r; // R05 R08
        latch_nxt = ctrl_r[DUTY_LSB_POS+1:DUTY_LSB_POS]; // R05
        level_nxt = (duty_new != 10'h000); // R04
      end else if (run_sel & (tb_nxt == duty_act)) begin
        level_nxt = 1'b0; // R12 R10 R14
      end
    end else begin
      level_nxt = 1'b0;
      if (wr_en & (address == OFS_ACTIVE_DUTY_BUFFER)) begin
        active_nxt = writedata[7:0]; // R09
      end
    end
    oe_n_nxt = ~((ctrl_nxt[MODE_POS+3:MODE_POS+2] == MODE_PWM_HI) & ~dir_nxt); // R18 R19
    if (sys_rst) begin
      active_nxt = RST_DUTY; // R17
      latch_nxt = 2'h0;
      level_nxt = 1'b0;
      oe_n_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    active_r <= active_nxt;
    latch_r <= latch_nxt;
    level_r <= level_nxt;
    oe_n_r <= oe_n_nxt;
  end

  // timer a step spacing watch for the checks
  always_comb begin
    gap_nxt = gap_r;
    gap_ok_nxt = gap_ok_r;
    if (tcon_r[0][RUN_POS] & ~sleep_req) begin
      gap_nxt = tick[0] ? 6'h00 : gap_r + 6'h01;
    end
    if (tick[0]) begin
      gap_ok_nxt = 1'b1;
    end
    if (wr_en & ((address == OFS_TIMER_CTRL_A) | (address == OFS_PERIOD_COUNT_A))) begin
      gap_nxt = 6'h00;
      gap_ok_nxt = 1'b0;
    end
    if (sys_rst) begin
      gap_nxt = 6'h00;
      gap_ok_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    gap_r <= gap_nxt;
    gap_ok_r <= gap_ok_nxt;
  end

  // checks
  a_rollover_clears: assert property (@(posedge mclk) disable iff (sys_rst) // R03
    roll && !(wr_en && address == tmr_ofs(OFS_PERIOD_COUNT_A, s)) |=> tmr_r[$past(s)] == 8'h00)
    else $error("counter did not clear at period limit");

  a_duty_latched: assert property (@(posedge mclk) disable iff (sys_rst) // R05
    roll && pwm_mode |=> active_r == $past(duty_msbs_r) && latch_r == $past(ctrl_r[5:4]))
    else $error("duty not copied at rollover");

  a_period_start_high: assert property (@(posedge mclk) disable iff (sys_rst) // R04
    roll && pwm_mode |=> pwm_output_pin == ($past(duty_new) != 10'h000))
    else $error("pin level wrong at period start");

  a_match_drives_low: assert property (@(posedge mclk) disable iff (sys_rst) // R12
    pwm_mode && !roll && run_sel && tb_nxt == duty_act |=> !pwm_output_pin)
    else $error("pin not cleared on compare match");

  a_sleep_freeze: assert property (@(posedge mclk) disable iff (sys_rst) // R16
    sleep_req && !wr_en |=> $stable(tmr_r[0]) && $stable(pwm_output_pin) && $stable(active_r))
    else $error("state moved during sleep");

  a_active_readonly: assert property (@(posedge mclk) disable iff (sys_rst) // R09
    wr_en && address == OFS_ACTIVE_DUTY_BUFFER && pwm_mode && !roll |=> $stable(active_r))
    else $error("active duty buffer written in pwm mode");

  a_reset_input: assert property (@(posedge mclk) // R17
    sys_rst |=> pwm_output_pin_oe_n && ctrl_r == RST_CHANNEL_CONTROL && tmr_r[0] == RST_PERIOD_COUNT)
    else $error("reset did not release pin");

  a_clear_releases: assert property (@(posedge mclk) disable iff (sys_rst) // R19
    ctrl_r == 8'h00 |-> pwm_output_pin_oe_n)
    else $error("pin driven with channel cleared");

  a_tick_spacing: assert property (@(posedge mclk) disable iff (sys_rst) // R20
    tick[0] && tcon_r[0][1:0] == CKPS_1 && $stable(tcon_r[0]) |=> !tick[0] [*3])
    else $error("counter stepped too early");

  a_postscale_free: assert property (@(posedge mclk) disable iff (sys_rst) // R06
    tcon_r[0][RUN_POS] && !sleep_req |-> tick[0] == (presc_r[0] == presc_lim(tcon_r[0][1:0])))
    else $error("tick depends on more than prescale");

  a_tick_gap: assert property (@(posedge mclk) disable iff (sys_rst) // R20 R15
    tick[0] && gap_ok_r |-> gap_r == presc_lim(tcon_r[0][1:0]))
    else $error("counter step spacing wrong");

  a_duty_held: assert property (@(posedge mclk) disable iff (sys_rst) // R08
    pwm_mode && !roll |=> $stable(active_r) && $stable(latch_r))
    else $error("active duty moved inside a period");

  a_rise_at_start: assert property (@(posedge mclk) disable iff (sys_rst) // R04
    $rose(pwm_output_pin) |-> $past(roll))
    else $error("pin rose away from period start");

  a_idle_low: assert property (@(posedge mclk) disable iff (sys_rst) // R19
    !pwm_mode |=> !pwm_output_pin)
    else $error("pin high outside pwm mode");

  a_beyond_period: assert property (@(posedge mclk) disable iff (sys_rst) // R14
    pwm_mode && !roll && !wr_en && tmr_r[s] <= pr_r[s] && duty_act > {pr_r[s], 2'h3} |=> $stable(pwm_output_pin))
    else $error("pin changed with duty past period");

  a_period_end: assert property (@(posedge mclk) disable iff (sys_rst) // R13 R02
    roll |-> tb == {pr_r[s], 2'h3})
    else $error("time base short at period end");

  a_oe_needs_dir: assert property (@(posedge mclk) disable iff (sys_rst) // R18
    !pwm_output_pin_oe_n |-> !dir_r && pwm_mode)
    else $error("pin driven without direction cleared");

  a_sleep_prescaler: assert property (@(posedge mclk) disable iff (sys_rst) // R16
    sleep_req && !wr_en |=> $stable(presc_r[0]) && $stable(latch_r) && $stable(tmr_r[1]) && $stable(tmr_r[2]))
    else $error("timers moved during sleep");

  a_write_answered: assert property (@(posedge mclk) disable iff (sys_rst) // R08
    (read || write) && waitrequest |=> !waitrequest)
    else $error("bus request not answered");

  a_wait_pulse: assert property (@(posedge mclk) disable iff (sys_rst) // R08
    !waitrequest |=> waitrequest)
    else $error("waitrequest low too long");

  a_duty_concat: assert property (@(posedge mclk) disable iff (sys_rst) // R07
    roll && pwm_mode |=> {active_r, latch_r} == $past(duty_new))
    else $error("ten bit duty not assembled");

  a_reset_bus: assert property (@(posedge mclk) // R17
    sys_rst |=> waitrequest && readdata == 32'h0000_0000 && !pwm_output_pin)
    else $error("bus or pin not idle after reset");

  a_reset_core: assert property (@(posedge mclk) // R17
    sys_rst |=> active_r == RST_DUTY && latch_r == 2'h0 && dir_r == RST_PIN_DIRECTION && tsel_r == RST_TIMER_SELECT)
    else $error("core state not reset");

  a_roll_needs_run: assert property (@(posedge mclk) disable iff (sys_rst) // R01 R16
    roll |-> tcon_r[s][RUN_POS] && !sleep_req)
    else $error("rollover from a stopped timer");

  a_tb_phase: assert property (@(posedge mclk) disable iff (sys_rst) // R11
    tcon_r[s][1:0] == CKPS_1 |-> tb[1:0] == presc_r[s][1:0])
    else $error("time base low bits not clock phase");

endmodule // pwm_channel

//--- verif/pwm_load.sv
// external load on the pwm pin, measuring period and high time
module pwm_load (
  input wire logic mclk,
  input wire logic pwm_output_pin,
  input wire logic pwm_output_pin_oe_n,
  output int high_len,
  output int period_len
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lvl;
  logic lvl_d = 1'b0;
  int cnt = 0;
  int hcnt = 0;
  // released pin is pulled low by the load
  assign lvl = (pwm_output_pin_oe_n === 1'b0) ? pwm_output_pin : 1'b0;
  always @(posedge mclk) begin
    lvl_d <= lvl;
    hcnt <= lvl ? hcnt + 1 : 0;
    cnt <= (lvl && !lvl_d) ? 1 : cnt + 1;
    if (lvl && !lvl_d) begin
      period_len <= cnt;
    end
    if (!lvl && lvl_d) begin
      high_len <= hcnt;
    end
  end
endmodule // pwm_load

//--- verif/test_standard_pwm_channel.sv
// self-checking bench for the standard pwm channel
module test_standard_pwm_channel;
  import pwm_channel_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] writedata = 32'h0;
  logic sleep_req = 1'b0;
  logic [31:0] readdata;
  logic waitrequest;
  logic pwm_output_pin;
  logic pwm_output_pin_oe_n;
  logic [31:0] rd;
  int high_len;
  int period_len;
  int err_count = 0;
  int check_count = 0;
  always #20 mclk = ~mclk;
  pwm_channel pwm_channel_i (.mclk(mclk), .sys_rst(sys_rst), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .sleep_req(sleep_req), .pwm_output_pin(pwm_output_pin), .pwm_output_pin_oe_n(pwm_output_pin_oe_n));
  pwm_load pwm_load_i (.mclk(mclk), .pwm_output_pin(pwm_output_pin), .pwm_output_pin_oe_n(pwm_output_pin_oe_n),
    .high_len(high_len), .period_len(period_len));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    if (err_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic xfer(input logic [7:0] a, input logic wr, input logic [7:0] d, input logic [3:0] be);
    int n;
    n = 0;
    address <= a;
    writedata <= {24'h0, d};
    byteenable <= be;
    write <= wr;
    read <= ~wr;
    do begin
      @(posedge mclk);
      n++;
      if (n > 50) begin
        err_count++;
        summarize();
      end
    end while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d, 4'hF);
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    xfer(a, 1'b0, 8'h00, 4'hF);
    chk(what, rd, {24'h0, exp});
  endtask
  task automatic wave(input int cycles, input int per, input int hi);
    repeat (cycles) @(posedge mclk);
    chk("period", period_len, per);
    chk("high time", high_len, hi);
  endtask
  task automatic level_run(input string what, input logic exp);
    int k;
    k = 0;
    repeat (40) @(posedge mclk);
    repeat (20) begin
      @(posedge mclk);
      k += (pwm_output_pin === exp) ? 1 : 0;
    end
    chk(what, k, 20);
  endtask
  task automatic t_reset();
    chk("oe_n at reset", {31'h0, pwm_output_pin_oe_n}, 32'h1);
    rdchk("control", OFS_CHANNEL_CONTROL, 8'h00);
    rdchk("active duty", OFS_ACTIVE_DUTY_BUFFER, 8'h00);
    rdchk("pin direction", OFS_PIN_DIRECTION, 8'h01);
    rdchk("period limit a", OFS_PERIOD_LIMIT_A, 8'hFF);
    rdchk("period count a", OFS_PERIOD_COUNT_A, 8'h00);
    rdchk("unmapped", 8'hFC, 8'h00);
  endtask
  task automatic t_basic();
    wr(OFS_PERIOD_LIMIT_A, 8'h03);
    xfer(OFS_PERIOD_LIMIT_A, 1'b1, 8'h77, 4'h0);
    rdchk("limit after masked write", OFS_PERIOD_LIMIT_A, 8'h03);
    wr(OFS_TIMER_CTRL_A, 8'h04);
    wr(OFS_DUTY_SETTING_MSBS, 8'h02);
    wr(OFS_CHANNEL_CONTROL, 8'h0C);
    wr(OFS_PIN_DIRECTION, 8'h00);
    wave(80, 16, 8);
    wr(OFS_CHANNEL_CONTROL, 8'h1C);
    wave(80, 16, 9);
  endtask
  task automatic t_prescale();
    wr(OFS_TIMER_CTRL_A, 8'h7D);
    wave(260, 64, 36);
    wr(OFS_TIMER_CTRL_A, 8'h06);
    wave(1030, 256, 144);
    wr(OFS_TIMER_CTRL_A, 8'h04);
  endtask
  task automatic t_timers();
    wr(OFS_PERIOD_LIMIT_A + OFS_TIMER_STRIDE, 8'h01);
    wr(OFS_TIMER_CTRL_A + OFS_TIMER_STRIDE, 8'h04);
    wr(OFS_DUTY_SETTING_MSBS, 8'h01);
    wr(OFS_CHANNEL_CONTROL, 8'h0C);
    wr(OFS_TIMER_SELECT, 8'h01);
    wave(60, 8, 4);
    wr(8'(OFS_PERIOD_LIMIT_A + 2 * OFS_TIMER_STRIDE), 8'h00);
    wr(8'(OFS_TIMER_CTRL_A + 2 * OFS_TIMER_STRIDE), 8'h04);
    wr(OFS_DUTY_SETTING_MSBS, 8'h00);
    wr(OFS_CHANNEL_CONTROL, 8'h2C);
    wr(OFS_TIMER_SELECT, 8'h02);
    wave(40, 4, 2);
  endtask
  task automatic t_extremes();
    wr(OFS_DUTY_SETTING_MSBS, 8'hFF);
    level_run("pin with duty past period", 1'b1);
    wr(OFS_DUTY_SETTING_MSBS, 8'h00);
    wr(OFS_CHANNEL_CONTROL, 8'h0C);
    level_run("pin with zero duty", 1'b0);
  endtask
  task automatic t_sleep();
    sleep_req <= 1'b1;
    wr(OFS_DUTY_SETTING_MSBS, 8'h05);
    wr(OFS_PERIOD_COUNT_A, 8'h02);
    repeat (40) @(posedge mclk);
    rdchk("count in sleep", OFS_PERIOD_COUNT_A, 8'h02);
    rdchk("active duty in sleep", OFS_ACTIVE_DUTY_BUFFER, 8'h00);
    sleep_req <= 1'b0;
    repeat (10) @(posedge mclk);
    rdchk("active duty after rollover", OFS_ACTIVE_DUTY_BUFFER, 8'h05);
    wr(OFS_ACTIVE_DUTY_BUFFER, 8'hAA);
    rdchk("active duty after write", OFS_ACTIVE_DUTY_BUFFER, 8'h05);
  endtask
  task automatic t_release();
    wr(OFS_CHANNEL_CONTROL, 8'h00);
    repeat (3) @(posedge mclk);
    chk("oe_n after clear", {31'h0, pwm_output_pin_oe_n}, 32'h1);
    chk("pin after clear", {31'h0, pwm_output_pin}, 32'h0);
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_basic();
    t_prescale();
    t_timers();
    t_extremes();
    t_sleep();
    t_release();
    summarize();
  end
endmodule // test_standard_pwm_channel
